// >>> common/ssc_pkg.sv
// How it works
// R1: One current status word plus five saved words, one per exception mode.
// R2: Status words hold latest flags, interrupt disables and the operating mode.
// R3: Bytecode flag set means bytecode state; else compact flag picks native or compact.
// R4: Both flags set traps next instruction; handler entry forces native state.
// R5: Status move instructions never alter the bytecode flag of the current word.
// R6: Bytecode flag lies outside status and extension bytes, so legacy writes miss it.
// R7: While the abort mask is set, late bus errors are recorded and deferred.
// R8: With the mask clear and an abort pending, the abort exception is requested.
// R9: Abort mask is set on reset and on abort, IRQ or FIQ entry.
// R10: A pending abort is kept until abort mode can be entered safely.
// R11: System control registers are reached only by coprocessor transfers when privileged.
// R12: Any coprocessor instruction in User mode raises the undefined-instruction trap; the code traps only those whose condition passes.
// R13: Transfers decode condition, opcode one, transfer register, both selects, opcode two.
// R14: Primary select addresses 16 registers, each read-only, read/write, write-only or undefined.
// R15: Each register is usable only in its translation or protection unit mode.
// R16: Integer unit uses virtual, caches modified virtual, memories and bus physical addresses.
// R17: Reserved selects and access-type mismatches raise the undefined-instruction trap.
package ssc_pkg;

	// ----------------------------------------
	// Modes and status word layout
	// ----------------------------------------
	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1B;

	localparam int CSW_FLAG_LSB = 28;
	localparam int CSW_J        = 24;
	localparam int CSW_A        = 8;
	localparam int CSW_I        = 7;
	localparam int CSW_F        = 6;
	localparam int CSW_T        = 5;
	localparam int CSW_MODE_LSB = 0;
	localparam int SAVED_NUM    = 5;
	localparam logic [31:0] CSW_RESET  = 32'h0000_01D3;
	localparam logic [31:0] CSW_J_MASK = 32'h0100_0000;
	localparam logic [3:0]  MOVE_USER_BYTES = 4'h8;

	localparam logic [2:0] IDX_FIQ    = 3'h0;
	localparam logic [2:0] IDX_IRQ    = 3'h1;
	localparam logic [2:0] IDX_SVC    = 3'h2;
	localparam logic [2:0] IDX_ABT    = 3'h3;
	localparam logic [2:0] IDX_UND    = 3'h4;
	localparam logic [2:0] SAVED_NONE = 3'h7;

	// ----------------------------------------
	// Coprocessor transfer fields and access map
	// ----------------------------------------
	localparam int CP_COND_LSB = 28;
	localparam int CP_OP1_LSB  = 21;
	localparam int CP_LOAD     = 20;
	localparam int CP_PRI_LSB  = 16;
	localparam int CP_RD_LSB   = 12;
	localparam int CP_NUM_LSB  = 8;
	localparam int CP_OP2_LSB  = 5;
	localparam int CP_SEC_LSB  = 0;
	localparam logic [3:0] CP_SYSCTRL  = 4'hF;
	localparam logic [3:0] PRI_RESERVED = 4'h4;

	localparam logic [1:0] ACC_UNDEF = 2'h0;
	localparam logic [1:0] ACC_RO    = 2'h1;
	localparam logic [1:0] ACC_RW    = 2'h2;
	localparam logic [1:0] ACC_WO    = 2'h3;
	// Two bits per primary select, select 0 in the low bits
	localparam logic [31:0] ACC_TABLE  = 32'h882B_A8A9;
	// Bit 0 of a pair: allowed with translation unit; bit 1: with protection unit
	localparam logic [31:0] UNIT_TABLE = 32'hCC1D_FCFF;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_CSW        = 12'h000;
	localparam logic [11:0] OFS_SAVED_BASE = 12'h004;
	localparam logic [11:0] OFS_SAVED_LAST = 12'h014;
	localparam logic [11:0] OFS_CFG        = 12'h018;
	localparam logic [11:0] OFS_IRQ_STAT   = 12'h01C;
	localparam logic [11:0] OFS_IRQ_CLR    = 12'h020;
	localparam logic [11:0] OFS_IRQ_EN     = 12'h024;
	localparam logic [11:0] OFS_ABT_STAT   = 12'h028;
	localparam int CFG_XLATE = 0;
	localparam logic [31:0] CFG_RESET = 32'h0000_0001;

	localparam int EV_NUM      = 4;
	localparam int EV_CP_TRAP  = 0;
	localparam int EV_JT_TRAP  = 1;
	localparam int EV_LATE_ERR = 2;
	localparam int EV_ABT_REQ  = 3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ABT_IDLE = 2'b00,
		ABT_HELD = 2'b01,
		ABT_REQ  = 2'b11
	} ssc_abtState_t;

	typedef enum logic [1:0] {
		UNIT_INTEGER = 2'h0,
		UNIT_CACHE   = 2'h1,
		UNIT_MEMBUS  = 2'h2
	} ssc_unit_t;

	typedef enum logic [1:0] {
		ADDR_VIRT    = 2'h0,
		ADDR_MODVIRT = 2'h1,
		ADDR_PHYS    = 2'h2
	} ssc_addrKind_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] mode;
	} ssc_exc_t;

	typedef struct packed {
		logic        valid;
		logic        toSaved;
		logic [3:0]  bytes;
		logic [31:0] data;
	} ssc_stMove_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] nzcv;
	} ssc_flags_t;

	typedef struct packed {
		logic       done;
		logic       undef;
		logic       wr;
		logic       rd;
		logic [2:0] op1;
		logic [3:0] xfer;
		logic [3:0] priSel;
		logic [3:0] secSel;
		logic [2:0] op2;
	} ssc_cpResp_t;

	// ----------------------------------------
	// Shared decoding
	// ----------------------------------------
	function automatic logic [2:0] ssc_savedIdx(input logic [4:0] mode);
		case (mode)
			MODE_FIQ: ssc_savedIdx = IDX_FIQ;
			MODE_IRQ: ssc_savedIdx = IDX_IRQ;
			MODE_SVC: ssc_savedIdx = IDX_SVC;
			MODE_ABT: ssc_savedIdx = IDX_ABT;
			MODE_UND: ssc_savedIdx = IDX_UND;
			default:  ssc_savedIdx = SAVED_NONE;
		endcase
	endfunction

	function automatic logic [31:0] ssc_byteMask(input logic [3:0] bytes);
		ssc_byteMask = {{8{bytes[3]}}, {8{bytes[2]}}, {8{bytes[1]}}, {8{bytes[0]}}};
	endfunction

	function automatic logic ssc_condPass(input logic [3:0] cond, input logic [3:0] nzcv);
		logic n;
		logic z;
		logic c;
		logic v;
		n = nzcv[3];
		z = nzcv[2];
		c = nzcv[1];
		v = nzcv[0];
		case (cond)
			4'h0:    ssc_condPass = z;
			4'h1:    ssc_condPass = !z;
			4'h2:    ssc_condPass = c;
			4'h3:    ssc_condPass = !c;
			4'h4:    ssc_condPass = n;
			4'h5:    ssc_condPass = !n;
			4'h6:    ssc_condPass = v;
			4'h7:    ssc_condPass = !v;
			4'h8:    ssc_condPass = c && !z;
			4'h9:    ssc_condPass = !c || z;
			4'hA:    ssc_condPass = n == v;
			4'hB:    ssc_condPass = n != v;
			4'hC:    ssc_condPass = !z && (n == v);
			4'hD:    ssc_condPass = z || (n != v);
			4'hE:    ssc_condPass = 1'b1;
			default: ssc_condPass = 1'b0;
		endcase
	endfunction

	function automatic logic ssc_priAllowed(input logic [3:0] pri, input logic isWrite, input logic xlateMode);
		logic [1:0] acc;
		logic [1:0] unit;
		acc  = ACC_TABLE[{pri, 1'b0} +: 2];
		unit = UNIT_TABLE[{pri, 1'b0} +: 2];
		ssc_priAllowed = ((acc == ACC_RW) || (acc == ACC_RO && !isWrite) || (acc == ACC_WO && isWrite))
			&& (xlateMode ? unit[0] : unit[1]);
	endfunction

endpackage

// >>> hdl/ssc_status_sysctrl.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module ssc_status_sysctrl
	import ssc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output      logic [31:0]       prdata,
	output      logic              pready,
	output      logic              pslverr,
	input  wire logic              cpValid,
	input  wire logic [31:0]       cpInstr,
	input  wire logic              instrIssue,
	input  wire ssc_exc_t          exc,
	input  wire logic              excReturn,
	input  wire ssc_stMove_t       stMove,
	input  wire ssc_flags_t        flags,
	input  wire logic              lateBusErr,
	input  wire ssc_unit_t         addrUnit,
	output      logic [31:0]       csw,
	output      logic              bytecodeState,
	output      logic              compactState,
	output      logic              undefTrap,
	output      logic              abortReq,
	output      ssc_cpResp_t       cpResp,
	output      ssc_addrKind_t     addrKind,
	output      logic              irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0]        saved [SAVED_NUM];
	logic [31:0]        cfg;
	logic [EV_NUM-1:0]  irqStat;
	logic [EV_NUM-1:0]  irqEn;
	ssc_abtState_t      abtState;

	logic [31:0]        next_csw;
	logic [EV_NUM-1:0]  next_irqStat;
	logic [EV_NUM-1:0]  next_irqEn;
	ssc_abtState_t      next_abtState;

	// ----------------------------------------
	// Status word control
	// ----------------------------------------
	wire [2:0]  curIdx     = ssc_savedIdx(csw[CSW_MODE_LSB +: 5]);
	wire [2:0]  entryIdx   = ssc_savedIdx(exc.mode);
	wire        userMode   = csw[CSW_MODE_LSB +: 5] == MODE_USR;
	wire        entryFiq   = exc.mode == MODE_FIQ;
	wire        entryMasks = exc.mode == MODE_ABT || exc.mode == MODE_IRQ || entryFiq;
	wire        retValid   = excReturn && curIdx != SAVED_NONE;
	wire [3:0]  moveBytes  = userMode ? (stMove.bytes & MOVE_USER_BYTES) : stMove.bytes;
	// Bytecode flag never taken from a status move into the live word
	wire [31:0] moveLiveMask  = ssc_byteMask(moveBytes) & ~CSW_J_MASK; // R5 R6
	wire [31:0] moveSavedMask = ssc_byteMask(stMove.bytes);
	wire        moveLive   = stMove.valid && !stMove.toSaved;
	wire        moveSaved  = stMove.valid && stMove.toSaved && curIdx != SAVED_NONE;

	// Entry beats return beats status move; a flag update overrides the move's flag bits
	always_comb begin
		next_csw = csw;
		if (exc.valid) begin
			next_csw[CSW_MODE_LSB +: 5] = exc.mode; // R2
			next_csw[CSW_I] = 1'b1;
			next_csw[CSW_F] = csw[CSW_F] | entryFiq;
			next_csw[CSW_A] = csw[CSW_A] | entryMasks; // R9
			next_csw[CSW_J] = 1'b0; // R4
			next_csw[CSW_T] = 1'b0; // R4
		end else if (retValid) begin
			next_csw = saved[curIdx];
		end else begin
			if (moveLive) begin
				next_csw = (csw & ~moveLiveMask) | (stMove.data & moveLiveMask); // R5
			end
			if (flags.valid) begin
				next_csw[CSW_FLAG_LSB +: 4] = flags.nzcv; // R2
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			csw <= CSW_RESET; // R9
		end else begin
			csw <= next_csw;
		end
	end

	// Saved copy taken before the live word changes, so the handler sees the interrupted status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < SAVED_NUM; i++) begin
				saved[i] <= '0;
			end
		end else if (exc.valid && entryIdx != SAVED_NONE) begin
			saved[entryIdx] <= csw; // R1 R4
		end else if (moveSaved) begin
			saved[curIdx] <= (saved[curIdx] & ~moveSavedMask) | (stMove.data & moveSavedMask);
		end
	end

	// ----------------------------------------
	// Execution state and invalid flag pair
	// ----------------------------------------
	wire jtBoth = csw[CSW_J] && csw[CSW_T];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bytecodeState <= 1'b0;
			compactState  <= 1'b0;
			undefTrap     <= 1'b0;
		end else begin
			bytecodeState <= next_csw[CSW_J]; // R3
			compactState  <= !next_csw[CSW_J] && next_csw[CSW_T]; // R3
			undefTrap     <= instrIssue && jtBoth; // R4
		end
	end

	// ----------------------------------------
	// Imprecise abort deferral
	// ----------------------------------------
	wire abtEntry = exc.valid && exc.mode == MODE_ABT;

	// A fresh error in the entry cycle stays pending rather than being lost
	always_comb begin
		next_abtState = abtState;
		case (abtState)
			ABT_IDLE: begin
				if (lateBusErr) begin
					next_abtState = ABT_HELD; // R7
				end
			end
			ABT_HELD: begin
				if (!csw[CSW_A]) begin
					next_abtState = ABT_REQ; // R8
				end
			end
			ABT_REQ: begin
				if (abtEntry) begin
					next_abtState = lateBusErr ? ABT_HELD : ABT_IDLE;
				end else if (csw[CSW_A]) begin
					next_abtState = ABT_HELD; // R10
				end
			end
			default: next_abtState = ABT_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			abtState <= ABT_IDLE;
			abortReq <= 1'b0;
		end else begin
			abtState <= next_abtState;
			abortReq <= next_abtState == ABT_REQ; // R8
		end
	end

	// ----------------------------------------
	// System control coprocessor gating
	// ----------------------------------------
	wire [3:0] cpCond  = cpInstr[CP_COND_LSB +: 4];
	wire [2:0] cpOp1   = cpInstr[CP_OP1_LSB +: 3];
	wire       cpRead  = cpInstr[CP_LOAD];
	wire [3:0] cpPri   = cpInstr[CP_PRI_LSB +: 4];
	wire [3:0] cpRd    = cpInstr[CP_RD_LSB +: 4];
	wire [3:0] cpNum   = cpInstr[CP_NUM_LSB +: 4];
	wire [2:0] cpOp2   = cpInstr[CP_OP2_LSB +: 3];
	wire [3:0] cpSec   = cpInstr[CP_SEC_LSB +: 4];
	wire       cpPass  = ssc_condPass(cpCond, csw[CSW_FLAG_LSB +: 4]); // R13
	wire       cpOk    = ssc_priAllowed(cpPri, !cpRead, cfg[CFG_XLATE]); // R14 R15 R17
	wire       cpTrap  = cpValid && cpPass && (userMode || cpNum != CP_SYSCTRL || !cpOk); // R12 R17
	wire       cpGrant = cpValid && cpPass && !cpTrap; // R11

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpResp <= '0;
		end else begin
			cpResp.done  <= cpValid;
			cpResp.undef <= cpTrap; // R12
			cpResp.wr    <= cpGrant && !cpRead;
			cpResp.rd    <= cpGrant && cpRead;
			cpResp.op1   <= cpOp1; // R13
			cpResp.xfer  <= cpRd;
			cpResp.priSel <= cpPri;
			cpResp.secSel <= cpSec;
			cpResp.op2   <= cpOp2;
		end
	end

	// ----------------------------------------
	// Address kind per unit
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addrKind <= ADDR_VIRT;
		end else begin
			case (addrUnit)
				UNIT_INTEGER: addrKind <= ADDR_VIRT; // R16
				UNIT_CACHE:   addrKind <= ADDR_MODVIRT; // R16
				default:      addrKind <= ADDR_PHYS; // R16
			endcase
		end
	end

	// ----------------------------------------
	// APB slave, one wait state per access
	// ----------------------------------------
	wire        apbAcc   = psel && penable;
	wire        apbDone  = apbAcc && pready;
	wire        apbWr    = apbDone && pwrite;
	wire [11:0] regAddr  = 12'(paddr);
	wire        hitCsw   = regAddr == OFS_CSW;
	wire        hitSaved = regAddr >= OFS_SAVED_BASE && regAddr <= OFS_SAVED_LAST && regAddr[1:0] == 2'b00;
	wire [2:0]  savedSel = 3'((regAddr - OFS_SAVED_BASE) >> 2);
	wire        hitCfg   = regAddr == OFS_CFG;
	wire        hitStat  = regAddr == OFS_IRQ_STAT;
	wire        hitClr   = regAddr == OFS_IRQ_CLR;
	wire        hitEn    = regAddr == OFS_IRQ_EN;
	wire        hitAbt   = regAddr == OFS_ABT_STAT;
	wire        mapped   = hitCsw || hitSaved || hitCfg || hitStat || hitClr || hitEn || hitAbt;

	wire [31:0] rdMux =
		hitCsw   ? csw :
		hitSaved ? saved[savedSel] :
		hitCfg   ? cfg :
		hitStat  ? 32'(irqStat) :
		hitEn    ? 32'(irqEn) :
		hitAbt   ? {30'h0000_0000, abtState == ABT_REQ, abtState != ABT_IDLE} :
		32'h0000_0000;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apbAcc && !pready;
			prdata  <= (apbAcc && !pready && !pwrite) ? rdMux : 32'h0000_0000;
			pslverr <= apbAcc && !pready && !mapped;
		end
	end

	// Mode select drives register gating; byte lane 0 holds all writable bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg <= CFG_RESET;
		end else if (apbWr && hitCfg && pstrb[0]) begin
			cfg[CFG_XLATE] <= pwdata[CFG_XLATE]; // R15
		end
	end

	// ----------------------------------------
	// Interrupt status, enable and output
	// ----------------------------------------
	wire [EV_NUM-1:0] irqClr = (apbWr && hitClr && pstrb[0]) ? pwdata[EV_NUM-1:0] : '0;
	wire [EV_NUM-1:0] events;
	assign events[EV_CP_TRAP]  = cpTrap;
	assign events[EV_JT_TRAP]  = instrIssue && jtBoth;
	assign events[EV_LATE_ERR] = lateBusErr;
	assign events[EV_ABT_REQ]  = next_abtState == ABT_REQ && abtState != ABT_REQ;

	// Set wins over a clear in the same cycle
	assign next_irqStat = (irqStat & ~irqClr) | events;
	assign next_irqEn   = (apbWr && hitEn && pstrb[0]) ? pwdata[EV_NUM-1:0] : irqEn;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStat <= '0;
			irqEn   <= '0;
			irq     <= 1'b0;
		end else begin
			irqStat <= next_irqStat;
			irqEn   <= next_irqEn;
			irq     <= |(next_irqStat & next_irqEn);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_SAVE_IRQ: assert property ( // R1
		exc.valid && exc.mode == MODE_IRQ |=> saved[IDX_IRQ] == $past(csw)
	) else $error("Saved word for IRQ entry does not hold the prior status");

	AST_JT_TRAP: assert property ( // R4
		instrIssue && csw[CSW_J] && csw[CSW_T] |=> undefTrap && irqStat[EV_JT_TRAP]
	) else $error("Invalid flag pair did not raise the undefined trap");

	AST_ENTRY_NATIVE: assert property ( // R4
		exc.valid |=> !csw[CSW_J] && !csw[CSW_T] && !bytecodeState && !compactState
	) else $error("Exception entry did not force native state");

	AST_MOVE_KEEPS_J: assert property ( // R5
		stMove.valid && !stMove.toSaved && !exc.valid && !excReturn |=> $stable(csw[CSW_J])
	) else $error("Status move changed the bytecode flag");

	AST_DEFER: assert property ( // R7
		lateBusErr && abtState == ABT_IDLE && csw[CSW_A] |=> abtState == ABT_HELD ##1 (!abortReq || !$past(csw[CSW_A]))
	) else $error("Masked late error was not held");

	AST_TAKE: assert property ( // R8
		abtState == ABT_HELD && !csw[CSW_A] |-> ##[1:2] abortReq
	) else $error("Unmasked pending abort was not requested");

	AST_MASK_SET: assert property ( // R9
		exc.valid && (exc.mode == MODE_ABT || exc.mode == MODE_IRQ || exc.mode == MODE_FIQ) |=> csw[CSW_A]
	) else $error("Abort mask not set on entry");

	AST_RETAIN: assert property ( // R10
		abtState != ABT_IDLE && !(exc.valid && exc.mode == MODE_ABT) |=> abtState != ABT_IDLE
	) else $error("Pending abort dropped before abort entry");

	AST_USER_TRAP: assert property ( // R12
		cpValid && cpPass && csw[CSW_MODE_LSB +: 5] == MODE_USR |=> cpResp.undef && !cpResp.wr && !cpResp.rd
	) else $error("User mode coprocessor access not trapped");

	AST_RESERVED: assert property ( // R17
		cpValid && cpPass && cpPri == PRI_RESERVED |=> cpResp.undef && cpResp.done
	) else $error("Reserved primary select not trapped");

	AST_APB_WAIT: assert property (
		psel && penable && !pready |=> pready
	) else $error("APB answer missing after one wait state");

endmodule

// >>> verif/ssc_pipe_model.sv
`timescale 1ns/1ps
module ssc_pipe_model
	import ssc_pkg::*;
(
	input  wire logic clk,
	output logic       cpValid,
	output logic [31:0] cpInstr,
	output logic       instrIssue,
	output ssc_exc_t   exc,
	output logic       excReturn,
	output ssc_stMove_t stMove,
	output ssc_flags_t flags,
	output logic       lateBusErr
);
	initial begin
		{cpValid, cpInstr, instrIssue, exc, excReturn, stMove, flags, lateBusErr} = '0;
	end

	// ----------------------------------------
	// One request per call, held for one edge
	// ----------------------------------------
	// Ends on the falling edge so results are read settled
	task automatic pulse(input int k, input logic [36:0] v);
		@(posedge clk);
		case (k)
			0: {cpValid, cpInstr} <= {1'b1, v[31:0]};
			1: instrIssue <= 1'b1;
			2: exc <= {1'b1, v[4:0]};
			3: excReturn <= 1'b1;
			4: stMove <= {1'b1, v};
			5: flags <= {1'b1, v[3:0]};
			default: lateBusErr <= 1'b1;
		endcase
		@(posedge clk);
		{cpValid, instrIssue, exc.valid, excReturn, stMove.valid, flags.valid, lateBusErr} <= '0;
		@(negedge clk);
	endtask
endmodule

// >>> verif/test_status_and_sysctrl_access.sv
`timescale 1ns/1ps
module test_status_and_sysctrl_access
	import ssc_pkg::*;
;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, e, ok, w;
	logic cpValid, instrIssue, excReturn, lateBusErr, bytecodeState, compactState, undefTrap, abortReq, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, cpInstr, csw, r, v, lfsr;
	logic [3:0]  pstrb;
	ssc_exc_t      exc;
	ssc_stMove_t   stMove;
	ssc_flags_t    flags;
	ssc_unit_t     addrUnit;
	ssc_cpResp_t   cpResp;
	ssc_addrKind_t addrKind;
	int miscompares, checks_done;

	ssc_status_sysctrl ssc_status_sysctrl_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpValid(cpValid), .cpInstr(cpInstr),
		.instrIssue(instrIssue), .exc(exc), .excReturn(excReturn), .stMove(stMove), .flags(flags),
		.lateBusErr(lateBusErr), .addrUnit(addrUnit), .csw(csw), .bytecodeState(bytecodeState),
		.compactState(compactState), .undefTrap(undefTrap), .abortReq(abortReq), .cpResp(cpResp),
		.addrKind(addrKind), .irq(irq));
	ssc_pipe_model ssc_pipe_model_inst (.clk(clk), .cpValid(cpValid), .cpInstr(cpInstr),
		.instrIssue(instrIssue), .exc(exc), .excReturn(excReturn), .stMove(stMove), .flags(flags),
		.lateBusErr(lateBusErr));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function logic acc_ok(input int c, input logic wr, input logic m);
		case (c)
			4, 11, 12, 14: return 1'b0;
			0: return !wr;
			8: return wr && m;
			10: return m;
			default: return 1'b1;
		endcase
	endfunction

	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
		checks_done++;
		if (got !== ex) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, ex, got);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0000_0000);
		chk("prdata", ex, r);
	endtask

	task automatic print_verdict();
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		pstrb = 4'hF;
		addrUnit = UNIT_INTEGER;
		lfsr = 32'h9153_4272;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("csw", 32'h0000_01D3, csw);
		rdc(OFS_CFG, 32'h0000_0001);
		for (int i = 0; i < 5; i++) rdc(OFS_SAVED_BASE + 12'(4 * i), 32'h0000_0000);
		apb(1'b0, 12'h030, 32'h0000_0000);
		chk("pslverr", 32'h0000_0001, 32'(e));
		ssc_pipe_model_inst.pulse(0, 37'h0E10_0F10);
		chk("cpCond", 32'h0000_0008, 32'(cpResp[21:18]));
		ssc_pipe_model_inst.pulse(0, 37'hEE10_0E10);
		chk("cpNum", 32'h0000_000C, 32'(cpResp[21:18]));
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, OFS_CFG, 32'(m));
			for (int c = 0; c < 16; c++) for (int k = 0; k < 2; k++) begin
				v = rnd();
				w = k[0];
				ok = acc_ok(c, w, m[0]);
				ssc_pipe_model_inst.pulse(0, {5'h0, 8'hEE, v[2:0], !w, 4'(c), v[6:3], 4'hF, v[9:7], 1'b1, v[13:10]});
				chk("cpResp", {10'h000, 1'b1, !ok, ok && w, ok && !w, v[2:0], v[6:3], 4'(c), v[13:10], v[9:7]},
					32'(cpResp));
			end
		end
		apb(1'b1, OFS_CFG, 32'h0000_0001);
		for (int u = 0; u < 3; u++) begin
			@(posedge clk);
			addrUnit <= ssc_unit_t'(u);
			@(posedge clk);
			@(negedge clk);
			chk("addrKind", 32'(u), 32'(addrKind));
		end
		repeat (8) begin
			v = rnd();
			ssc_pipe_model_inst.pulse(5, 37'(v[3:0]));
			chk("flags", 32'(v[3:0]), 32'(csw[31:28]));
		end
		// A live status move tries to set the bytecode flag; a saved-word move and a return then set it
		ssc_pipe_model_inst.pulse(4, {1'b0, 4'hF, 32'h0100_01D3});
		chk("csw", 32'h0000_01D3, csw);
		ssc_pipe_model_inst.pulse(4, {1'b1, 4'hF, 32'h0100_01F3});
		ssc_pipe_model_inst.pulse(3, 37'h0);
		chk("state", 32'h0000_0002, {30'h0, bytecodeState, compactState});
		ssc_pipe_model_inst.pulse(1, 37'h0);
		chk("undefTrap", 32'h0000_0001, 32'(undefTrap));
		ssc_pipe_model_inst.pulse(2, 37'(MODE_UND));
		chk("csw", 32'h0000_01DB, csw);
		rdc(OFS_SAVED_LAST, 32'h0100_01F3);
		ssc_pipe_model_inst.pulse(6, 37'h0);
		repeat (4) begin
			@(negedge clk);
			chk("abortReq", 32'h0000_0000, 32'(abortReq));
		end
		rdc(OFS_ABT_STAT, 32'h0000_0001);
		ssc_pipe_model_inst.pulse(4, {1'b0, 4'h2, 32'h0000_0000});
		for (int k = 0; k < 4 && abortReq !== 1'b1; k++) @(negedge clk);
		chk("abortReq", 32'h0000_0001, 32'(abortReq));
		ssc_pipe_model_inst.pulse(2, 37'(MODE_ABT));
		chk("abortReq", 32'h0000_0000, 32'(abortReq));
		chk("csw", 32'h0000_01D7, csw);
		rdc(OFS_SAVED_BASE + 12'h00C, 32'h0000_00DB);
		for (int k = 0; k < 2; k++) begin
			ssc_pipe_model_inst.pulse(4, {1'b0, 4'h2, 32'h0000_0000});
			ssc_pipe_model_inst.pulse(2, 37'(k ? MODE_IRQ : MODE_FIQ));
			chk("maskA", 32'h0000_0001, 32'(csw[8]));
		end
		apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
		apb(1'b1, OFS_IRQ_CLR, 32'h0000_000F);
		rdc(OFS_IRQ_STAT, 32'h0000_0000);
		chk("irq", 32'h0000_0000, 32'(irq));
		ssc_pipe_model_inst.pulse(4, {1'b0, 4'h1, 32'h0000_0010});
		ssc_pipe_model_inst.pulse(0, 37'hEE11_0F10);
		chk("cpUser", 32'h0000_000C, 32'(cpResp[21:18]));
		@(negedge clk);
		chk("irq", 32'h0000_0001, 32'(irq));
		rdc(OFS_IRQ_STAT, 32'h0000_0001);
		apb(1'b1, OFS_IRQ_EN, 32'h0000_0000);
		@(negedge clk);
		chk("irq", 32'h0000_0000, 32'(irq));
		print_verdict();
	end
endmodule
